// *** rtl/dsp_pkg.sv ***
// shared constants and carrier types of the display serial host port
`default_nettype none
package dsp_pkg;
    // bits in one serial byte, shifted most significant first
    localparam logic [3:0] DSP_BITS_PER_BYTE = 4'h8;
    // reset values of the synchronised pins (idle, deselected)
    localparam logic DSP_CSN_RST = 1'h1;
    localparam logic DSP_CS_RST = 1'h0;
    localparam logic DSP_RSTN_PIN_RST = 1'h1;
    // least low time of the panel reset pin, and its cycle count
    localparam int DSP_CLK_PERIOD_NS = 20;
    localparam int DSP_RESET_MIN_NS = 20000;
    localparam int DSP_RESET_MIN_CYC =
        (DSP_RESET_MIN_NS + DSP_CLK_PERIOD_NS - 1) / DSP_CLK_PERIOD_NS;
    localparam int DSP_RCNT_W = 11;
    localparam logic [DSP_RCNT_W-1:0] DSP_RESET_MIN_CNT =
        DSP_RCNT_W'(DSP_RESET_MIN_CYC);

    // pins coming from the host, all asynchronous to clk
    typedef struct packed {
        logic chip_select_active_low;
        logic chip_select_active_high;
        logic data_cmd_sel;
        logic data_line_zero;   // serial clock
        logic data_line_one;    // serial data in
        logic panel_reset_n;
    } dsp_pins_s;

    localparam dsp_pins_s DSP_PINS_RST = '{
        chip_select_active_low: DSP_CSN_RST,
        chip_select_active_high: DSP_CS_RST,
        data_cmd_sel: 1'h0,
        data_line_zero: 1'h0,
        data_line_one: 1'h0,
        panel_reset_n: DSP_RSTN_PIN_RST};

    // one received byte with its command or data class
    typedef struct packed {
        logic is_data;
        logic [7:0] value;
    } dsp_byte_s;
endpackage : dsp_pkg
`default_nettype wire

// *** rtl/dsp_serial_port.sv ***
// serial control port of the display driver: pins in, bytes and busy out
`default_nettype none
module dsp_serial_port
    import dsp_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // host pins
    input wire dsp_pins_s pins,
    // panel driver side
    input wire logic waveform_active,
    output logic busy,
    // received bytes
    output dsp_byte_s rx_byte,
    output logic rx_valid,
    // initialisation control
    output logic init_start,
    output logic reset_short
);
    // two-stage synchroniser plus one history stage for edge finding
    dsp_pins_s pins_q1_r;
    dsp_pins_s pins_q2_r;
    dsp_pins_s pins_q3_r;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [3:0] bit_cnt_r;
    logic [3:0] bit_cnt_nxt;
    dsp_byte_s rx_byte_nxt;
    logic rx_valid_nxt;
    logic busy_r;
    logic init_start_r;
    logic reset_short_r;
    logic [DSP_RCNT_W-1:0] rlow_cnt_r;

    // decoded pin conditions, read only from the second stage onward
    wire logic sel;
    wire logic sclk_rise;
    wire logic last_bit;
    wire logic rst_fall;
    wire logic rst_rise;
    assign sel = !pins_q2_r.chip_select_active_low
               && pins_q2_r.chip_select_active_high;
    assign sclk_rise = sel && pins_q2_r.data_line_zero
                     && !pins_q3_r.data_line_zero;
    assign last_bit = (bit_cnt_r == DSP_BITS_PER_BYTE - 4'h1);
    assign rst_fall = !pins_q2_r.panel_reset_n && pins_q3_r.panel_reset_n;
    assign rst_rise = pins_q2_r.panel_reset_n && !pins_q3_r.panel_reset_n;

    // pin synchroniser; q1 feeds q2 only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_q1_r <= DSP_PINS_RST;
            pins_q2_r <= DSP_PINS_RST;
            pins_q3_r <= DSP_PINS_RST;
        end else if (ce) begin
            pins_q1_r <= pins;
            pins_q2_r <= pins_q1_r;
            pins_q3_r <= pins_q2_r;
        end
    end

    // shifter: msb arrives first, so each bit enters at the bottom
    always_comb begin
        shift_nxt = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        rx_byte_nxt = rx_byte;
        rx_valid_nxt = 1'h0;
        if (!sel || !pins_q2_r.panel_reset_n) begin
            // deselect or panel reset drops a partial byte
            bit_cnt_nxt = 4'h0;
        end else if (sclk_rise) begin
            shift_nxt = {shift_r[6:0], pins_q2_r.data_line_one};
            if (last_bit) begin
                bit_cnt_nxt = 4'h0;
                rx_valid_nxt = 1'h1;
                rx_byte_nxt.value = {shift_r[6:0], pins_q2_r.data_line_one};
                // class is taken with the final bit of the byte
                rx_byte_nxt.is_data = pins_q2_r.data_cmd_sel;
            end else begin
                bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
        end
    end

    // byte registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            rx_byte <= '0;
            rx_valid <= 1'h0;
        end else if (ce) begin
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            rx_byte <= rx_byte_nxt;
            rx_valid <= rx_valid_nxt;
        end
    end

    // reset pin: start init on the fall, flag a pulse shorter than minimum
    // the width check only reports; init has already begun on the fall
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            init_start_r <= 1'h0;
            reset_short_r <= 1'h0;
            rlow_cnt_r <= '0;
        end else if (ce) begin
            init_start_r <= rst_fall;
            reset_short_r <= rst_rise
                          && (rlow_cnt_r < DSP_RESET_MIN_CNT);
            if (pins_q2_r.panel_reset_n) begin
                rlow_cnt_r <= '0;
            end else if (rlow_cnt_r != DSP_RESET_MIN_CNT) begin
                rlow_cnt_r <= rlow_cnt_r + DSP_RCNT_W'(1);
            end
        end
    end

    // busy follows the panel waveform, registered for a clean pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_r <= 1'h0;
        end else if (ce) begin
            busy_r <= waveform_active;
        end
    end

    assign busy = busy_r;
    assign init_start = init_start_r;
    assign reset_short = reset_short_r;

    // checks
    property p_dc_class;
        @(posedge clk) disable iff (!rst_n)
        (rx_valid && $past(ce))
            |-> rx_byte.is_data == $past(pins_q2_r.data_cmd_sel);
    endproperty
    a_dc_class: assert property (p_dc_class)
        else $error("byte class differs from select line");

    property p_desel_clear;
        @(posedge clk) disable iff (!rst_n)
        (ce && !sel) |=> bit_cnt_r == 4'h0;
    endproperty
    a_desel_clear: assert property (p_desel_clear)
        else $error("bit count kept while deselected");

    property p_byte_needs_sel;
        @(posedge clk) disable iff (!rst_n)
        (rx_valid && $past(ce)) |-> $past(sel) && $past(last_bit);
    endproperty
    a_byte_needs_sel: assert property (p_byte_needs_sel)
        else $error("byte delivered without selection");

    property p_byte_value;
        @(posedge clk) disable iff (!rst_n)
        (rx_valid && $past(ce)) |-> rx_byte.value
            == {$past(shift_r[6:0]), $past(pins_q2_r.data_line_one)};
    endproperty
    a_byte_value: assert property (p_byte_value)
        else $error("byte value not taken from data line one");

    property p_init_start;
        @(posedge clk) disable iff (!rst_n)
        (ce && rst_fall) |=> init_start;
    endproperty
    a_init_start: assert property (p_init_start)
        else $error("init not started on reset fall");

    property p_init_cause;
        @(posedge clk) disable iff (!rst_n)
        (init_start && $past(ce)) |-> $past(rst_fall);
    endproperty
    a_init_cause: assert property (p_init_cause)
        else $error("init started without reset fall");

    property p_busy_follow;
        @(posedge clk) disable iff (!rst_n)
        (ce && !waveform_active) ##1 (ce && !waveform_active) |=> !busy;
    endproperty
    a_busy_follow: assert property (p_busy_follow)
        else $error("busy high without waveform");

    property p_busy_high;
        @(posedge clk) disable iff (!rst_n)
        (ce && waveform_active) |=> busy;
    endproperty
    a_busy_high: assert property (p_busy_high)
        else $error("busy low during waveform");

    // a short-pulse report only ever follows a seen release of the pin
    property p_short_cause;
        @(posedge clk) disable iff (!rst_n)
        (reset_short && $past(ce)) |-> $past(rst_rise);
    endproperty
    a_short_cause: assert property (p_short_cause)
        else $error("short reset reported without pin release");

    // a frozen port must not move its outputs while the enable is low
    property p_ce_freeze;
        @(posedge clk) disable iff (!rst_n)
        !ce |=> $stable(rx_byte) && $stable(rx_valid) && $stable(busy);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("outputs moved while clock enable low");

    c_data_byte: cover property (@(posedge clk) rx_valid && rx_byte.is_data);
    c_cmd_byte: cover property (@(posedge clk) rx_valid && !rx_byte.is_data);
    c_init: cover property (@(posedge clk) init_start);
    c_short: cover property (@(posedge clk) reset_short);
    // a partial byte dropped by deselection
    c_partial: cover property (@(posedge clk) bit_cnt_r != 4'h0 && !sel);
endmodule // dsp_serial_port
`default_nettype wire

// *** test/dsp_host_model.sv ***
// host side model driving the serial port pins
`default_nettype none
module dsp_host_model
    import dsp_pkg::*;
(
    // clock
    input wire logic clk,
    // pins towards the port
    output var dsp_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins idle and deselected from time zero
    initial pins = DSP_PINS_RST;

    // half a serial clock period is 4 clk cycles (160 ns period)
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // n bits of one byte in one frame; bad leaves the high select off
    task automatic send(input logic d, input logic [7:0] v, input int n,
        input logic bad);
        pins.chip_select_active_low = 1'h0;
        pins.chip_select_active_high = ~bad;
        pins.data_cmd_sel = d;
        for (int i = 7; i > 7 - n; i--) begin
            pins.data_line_one = v[i];
            half();
            pins.data_line_zero = 1'h1;
            half();
            pins.data_line_zero = 1'h0;
        end
        half();
        pins.chip_select_active_low = 1'h1;
        pins.chip_select_active_high = 1'h0;
        // a released data line must not keep looking valid
        pins.data_line_one = ~pins.data_line_one;
        // deselect stands long enough for the port to see it
        half();
    endtask

    // reset pin held low for cyc clk cycles
    task automatic reset_pulse(input int cyc);
        pins.panel_reset_n = 1'h0;
        repeat (cyc) @(posedge clk);
        #1;
        pins.panel_reset_n = 1'h1;
    endtask
endmodule // dsp_host_model
`default_nettype wire

// *** test/dsp_serial_port_tb.sv ***
// self-checking bench of the display serial host port
`default_nettype none
module dsp_serial_port_tb
    import dsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, ce, wave, busy, rx_valid, init_start, reset_short;
    dsp_pins_s pins;
    dsp_byte_s rx_byte, last;
    int fails = 0, compares = 0, nbytes = 0, ninit = 0, nshort = 0;
    dsp_byte_s rows [4] = '{9'h1a5, 9'h03c, 9'h180, 9'h0ff};
    int widths [3] = '{10, DSP_RESET_MIN_CYC - 1, DSP_RESET_MIN_CYC};

    // enable driven: one test freezes the whole port
    dsp_serial_port i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .pins(pins),
        .waveform_active(wave), .busy(busy), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .init_start(init_start),
        .reset_short(reset_short));
    dsp_host_model i_host (.clk(clk), .pins(pins));

    // 50 MHz clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // counts the one-cycle pulses at every rising edge
    always @(posedge clk) begin
        if (rx_valid === 1'h1) begin
            nbytes++;
            last = rx_byte;
        end
        if (init_start === 1'h1) ninit++;
        if (reset_short === 1'h1) nshort++;
    end

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cmp_val(input dsp_byte_s got, input dsp_byte_s exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_num(input int got, input int exp);
        compares++;
        if (got != exp) begin
            fails++;
            $display("FAIL %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // main sequence
    initial begin
        rst_n = 1'h0;
        ce = 1'h1;
        wave = 1'h0;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'h1;
        cmp_bit(busy | rx_valid | init_start | reset_short, 1'h0);
        cmp_val(rx_byte, 9'h000);
        $display("test reset done");
        foreach (rows[i]) begin
            i_host.send(rows[i].is_data, rows[i].value, 8, 1'h0);
            cmp_num(nbytes, i + 1);
            cmp_val(last, rows[i]);
        end
        $display("test rows done");
        // partial byte dropped at deselect, then a whole command
        i_host.send(1'h1, 8'hc3, 5, 1'h0);
        i_host.send(1'h0, 8'h5a, 8, 1'h0);
        cmp_num(nbytes, 5);
        cmp_val(last, 9'h05a);
        i_host.send(1'h1, 8'h77, 8, 1'h1);
        cmp_num(nbytes, 5);
        $display("test framing done");
        wave = 1'h1;
        repeat (3) @(posedge clk);
        #1;
        cmp_bit(busy, 1'h1);
        wave = 1'h0;
        @(posedge clk);
        #1;
        cmp_bit(busy, 1'h0);
        $display("test busy done");
        // frozen port ignores a whole frame and a waveform
        wait (busy == 1'h0);
        ce = 1'h0;
        wave = 1'h1;
        i_host.send(1'h0, 8'h81, 8, 1'h0);
        cmp_num(nbytes, 5);
        cmp_bit(busy, 1'h0);
        wave = 1'h0;
        ce = 1'h1;
        $display("test enable done");
        // short, just short and just long enough reset pulses
        for (int k = 0; k < 3; k++) begin
            i_host.reset_pulse(widths[k]);
            repeat (5) @(posedge clk);
            #1;
            cmp_num(ninit, k + 1);
            cmp_num(nshort, (k < 2) ? k + 1 : 2);
        end
        $display("test reset pin done");
        // mid-run reset clears the held byte, then a byte still lands
        rst_n = 1'h0;
        @(posedge clk);
        #1;
        rst_n = 1'h1;
        cmp_val(rx_byte, 9'h000);
        i_host.send(1'h1, 8'h96, 8, 1'h0);
        cmp_num(nbytes, 6);
        cmp_val(last, 9'h196);
        $display("test mid reset done");
        print_verdict();
    end

    // watchdog well beyond the roughly 2700 cycles the tests take
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("FAIL %0t watchdog expired", $time);
        print_verdict();
    end
endmodule // dsp_serial_port_tb
`default_nettype wire
